// File: design/spi_consts.svh
// Offsets, field positions, reset values and rate ratios of the serial port
//
// Overview of operation
// - One transmit buffer; no load during shifting
// - Received byte held until next completes
// - External clock low and high over two cycles
// - Enabled port forces pin directions by role
// - Slave select input; MISO drives when selected
// - Deselect resets slave logic, drops partial byte
// - Master select-output pin is plain output
// - Low select input drops master, sets done
// - Interrupt needs enable, done, global enable
// - Port enable gates all serial activity
// - Bit order select, one sends LSB first
// - Role select, one means master
// - Clock idle level and edge polarity
// - Phase picks sample edge and setup edge
// - Rate bits and double rate divide clock
// - Rate bits ignored in slave mode
// - Master data write starts eight-bit clocking
// - Done flag set per byte, cleared by sequence
// - Double rate gives two-cycle minimum period
`ifndef SPI_CONSTS_SVH
`define SPI_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CONTROL    8'h00
`define OFF_STATUS     8'h04
`define OFF_DATA       8'h08
`define OFF_PINS       8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_IRQ_EN     7
`define BIT_PORT_EN    6
`define BIT_LSB_FIRST  5
`define BIT_MASTER     4
`define BIT_IDLE_LVL   3
`define BIT_PHASE      2
`define BIT_DONE       7
`define BIT_DOUBLE     0
`define PIN_MOSI_DIR   0
`define PIN_MISO_DIR   1
`define PIN_SCK_DIR    2
`define PIN_SS_DIR     3
`define PIN_SS_LEVEL   4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CONTROL_RESET  8'h00
`define PINS_RESET     5'h00

// ----------------------------------------
// Clock divide ratios and counts
// ----------------------------------------
`define DIV_NORM_0     8'h04
`define DIV_NORM_1     8'h10
`define DIV_NORM_2     8'h40
`define DIV_NORM_3     8'h80
`define DIV_DBL_0      8'h02
`define DIV_DBL_1      8'h08
`define DIV_DBL_2      8'h20
`define DIV_DBL_3      8'h40
`define LAST_EDGE      4'hf
`define LAST_BIT       4'h7
`define PEER_HALF      3

`endif

// File: design/spi_link_if.sv
// Four-wire serial link joining the port and its partner
`timescale 1ns/100ps
interface spi_link_if;
  logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
  logic dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe;
  logic peer_sck_o, peer_sck_oe, peer_mosi_o, peer_mosi_oe;
  logic peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe;
  logic sck, mosi, miso, ss_n;

  // Undriven wires float high through pull-ups
  assign sck  = dev_sck_oe  ? dev_sck_o  : (peer_sck_oe  ? peer_sck_o  : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (peer_mosi_oe ? peer_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : (peer_miso_oe ? peer_miso_o : 1'b1);
  assign ss_n = dev_ss_oe   ? dev_ss_o   : (peer_ss_oe   ? peer_ss_o   : 1'b1);

  modport dev (
    output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
    output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
    input  sck, mosi, miso, ss_n
  );
  modport peer (
    output peer_sck_o, peer_sck_oe, peer_mosi_o, peer_mosi_oe,
    output peer_miso_o, peer_miso_oe, peer_ss_o, peer_ss_oe,
    input  sck, mosi, miso, ss_n
  );
endinterface : spi_link_if

// File: design/spi_peer.sv
// Partner end of the serial link, acting as master or slave
`timescale 1ns/100ps
`include "spi_consts.svh"
module spi_peer
  import spi_pkg::*;
#(
  parameter int HALF_PERIOD = `PEER_HALF
)(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       role_master,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_sample_phase,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_data,
  input  wire logic       start,
  output logic            busy,
  output logic      [7:0] rx_data,
  output logic            done,
  spi_link_if.peer        link
);
  peer_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt, cnt_r, cnt_nxt, rx_nxt, po_r, po_nxt;
  logic [3:0] ecnt_r, ecnt_nxt, bcnt_r, bcnt_nxt;
  logic       sck_r, sck_nxt, ss_r, ss_nxt, out_r, out_nxt, prev_r;
  logic       done_nxt, busy_nxt, top, samp, tick;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r; sh_nxt = sh_r; cnt_nxt = cnt_r + 8'h01; rx_nxt = rx_data;
    ecnt_nxt = ecnt_r; bcnt_nxt = bcnt_r; sck_nxt = sck_r; ss_nxt = ss_r;
    out_nxt = out_r; done_nxt = 1'b0;
    top  = lsb_first ? sh_r[0] : sh_r[7];
    // Each level lasts more than two cycles so the port can see it
    tick = (cnt_r == 8'(HALF_PERIOD - 1));
    samp = 1'b0;
    unique case (st_r)
      P_IDLE: begin
        sck_nxt = clock_idle_level;
        ss_nxt  = 1'b1;
        if (start && (role_master || link.ss_n)) begin
          sh_nxt  = tx_data;
          out_nxt = lsb_first ? tx_data[0] : tx_data[7];
          if (role_master) begin
            st_nxt  = P_LEAD;
            ss_nxt  = 1'b0;
            cnt_nxt = 8'h00;
          end
        end else if (!role_master) begin
          if (link.ss_n) begin
            bcnt_nxt = 4'h0;
          end else if (link.sck != prev_r) begin
            if ((prev_r == clock_idle_level) ^ clock_sample_phase) begin
              samp     = 1'b1;
              sh_nxt   = lsb_first ? {link.mosi, sh_r[7:1]} : {sh_r[6:0], link.mosi};
              bcnt_nxt = bcnt_r + 4'h1;
              if (bcnt_r == `LAST_BIT) begin
                bcnt_nxt = 4'h0;
                rx_nxt   = sh_nxt;
                done_nxt = 1'b1;
              end
            end else begin
              out_nxt = top;
            end
          end
        end
      end
      P_LEAD: begin
        if (tick) begin
          st_nxt   = P_SHIFT;
          cnt_nxt  = 8'h00;
          ecnt_nxt = 4'h0;
        end
      end
      P_SHIFT: begin
        if (tick) begin
          cnt_nxt  = 8'h00;
          sck_nxt  = ~sck_r;
          ecnt_nxt = ecnt_r + 4'h1;
          if (~ecnt_r[0] ^ clock_sample_phase) begin
            sh_nxt = lsb_first ? {link.miso, sh_r[7:1]} : {sh_r[6:0], link.miso};
          end else begin
            out_nxt = top;
          end
          if (ecnt_r == `LAST_EDGE) begin
            st_nxt = P_TAIL;
          end
        end
      end
      P_TAIL: begin
        if (tick) begin
          st_nxt   = P_IDLE;
          ss_nxt   = 1'b1;
          rx_nxt   = sh_r;
          done_nxt = 1'b1;
        end
      end
    endcase
    busy_nxt = (st_nxt != P_IDLE) || (bcnt_nxt != 4'h0);
    // Pin order: sck, mosi, miso, ss values then enables
    po_nxt = role_master ? {sck_r, out_r, 1'b0, ss_r, 1'b1, 1'b1, 1'b0, 1'b1}
                         : {1'b0, 1'b0, out_r, 1'b1, 1'b0, 1'b0, ~link.ss_n, 1'b0};
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= P_IDLE; sh_r <= 8'h00; cnt_r <= 8'h00; rx_data <= 8'h00;
      ecnt_r <= 4'h0; bcnt_r <= 4'h0; sck_r <= 1'b0; ss_r <= 1'b1;
      out_r <= 1'b0; prev_r <= 1'b1; done <= 1'b0; busy <= 1'b0; po_r <= 8'h00;
    end else begin
      st_r <= st_nxt; sh_r <= sh_nxt; cnt_r <= cnt_nxt; rx_data <= rx_nxt;
      ecnt_r <= ecnt_nxt; bcnt_r <= bcnt_nxt; sck_r <= sck_nxt; ss_r <= ss_nxt;
      out_r <= out_nxt; prev_r <= link.sck; done <= done_nxt; busy <= busy_nxt;
      po_r <= po_nxt;
    end
  end

  assign link.peer_sck_o   = po_r[7];
  assign link.peer_mosi_o  = po_r[6];
  assign link.peer_miso_o  = po_r[5];
  assign link.peer_ss_o    = po_r[4];
  assign link.peer_sck_oe  = po_r[3];
  assign link.peer_mosi_oe = po_r[2];
  assign link.peer_miso_oe = po_r[1];
  assign link.peer_ss_oe   = po_r[0];
endmodule : spi_peer

// File: design/spi_pkg.sv
// Types shared by both ends of the serial link
package spi_pkg;
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b01,
    DEV_RUN  = 2'b10
  } dev_state_t;

  typedef enum logic [3:0] {
    P_IDLE  = 4'b0001,
    P_LEAD  = 4'b0010,
    P_SHIFT = 4'b0100,
    P_TAIL  = 4'b1000
  } peer_state_t;
endpackage : spi_pkg

// File: design/spi_port.sv
// Serial peripheral port, master or slave, with APB register access
`timescale 1ns/100ps
`include "spi_consts.svh"
module spi_port
  import spi_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_ack,
  output logic             irq,
  spi_link_if.dev          link
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  dev_state_t  st_r, st_nxt;
  logic [7:0]  ctl_r, ctl_nxt;
  logic        dbl_r, dbl_nxt;
  logic [4:0]  pin_r, pin_nxt;
  logic        flag_r, flag_nxt;
  logic        arm_r, arm_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [7:0]  rxbuf_r, rxbuf_nxt;
  logic        out_r, out_nxt;
  logic [3:0]  ecnt_r, ecnt_nxt;
  logic [3:0]  bcnt_r, bcnt_nxt;
  logic [6:0]  dcnt_r, dcnt_nxt;
  logic        sck_r, sck_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt, pslverr_nxt, irq_nxt;
  logic        ss_s1, ss_s2, sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2;
  logic [7:0]  po_r, po_nxt;

  logic        en, mst, lsbf, clock_idle_level, clock_sample_phase, top, acc, busy, lead, done;
  logic [7:0]  div;
  logic [6:0]  half_m1;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    en   = ctl_r[`BIT_PORT_EN];
    mst  = ctl_r[`BIT_MASTER];
    lsbf = ctl_r[`BIT_LSB_FIRST];
    clock_idle_level = ctl_r[`BIT_IDLE_LVL];
    clock_sample_phase = ctl_r[`BIT_PHASE];
    top  = lsbf ? sh_r[0] : sh_r[7];
    acc  = psel & penable & pready;
    busy = (st_r == DEV_RUN) || (bcnt_r != 4'h0);
    done = 1'b0;
    lead = 1'b0;
    st_nxt = st_r; ctl_nxt = ctl_r; dbl_nxt = dbl_r; pin_nxt = pin_r;
    flag_nxt = flag_r; arm_nxt = arm_r; sh_nxt = sh_r; rxbuf_nxt = rxbuf_r;
    out_nxt = out_r; ecnt_nxt = ecnt_r; bcnt_nxt = bcnt_r; dcnt_nxt = dcnt_r;
    sck_nxt = sck_r; prdata_nxt = prdata; pready_nxt = 1'b0; pslverr_nxt = 1'b0;
    po_nxt = po_r;

    unique case ({dbl_r, ctl_r[1:0]})
      3'h0: div = `DIV_NORM_0;
      3'h1: div = `DIV_NORM_1;
      3'h2: div = `DIV_NORM_2;
      3'h3: div = `DIV_NORM_3;
      3'h4: div = `DIV_DBL_0;
      3'h5: div = `DIV_DBL_1;
      3'h6: div = `DIV_DBL_2;
      3'h7: div = `DIV_DBL_3;
    endcase
    half_m1 = div[7:1] - 7'h01;

    // Setup cycle prepares the answer so the access phase ends at once
    if (psel && !penable) begin
      pready_nxt = 1'b1;
      case (paddr)
        `OFF_CONTROL: prdata_nxt = {24'h000000, ctl_r};
        `OFF_STATUS:  prdata_nxt = {24'h000000, flag_r, 6'h00, dbl_r};
        `OFF_DATA:    prdata_nxt = {24'h000000, rxbuf_r};
        `OFF_PINS:    prdata_nxt = {27'h0000000, pin_r};
        default: begin
          prdata_nxt  = 32'h00000000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end

    if (acc && !pslverr) begin
      if (paddr == `OFF_STATUS && !pwrite) begin
        arm_nxt = prdata[`BIT_DONE];
      end
      if (paddr == `OFF_DATA && arm_r) begin
        flag_nxt = 1'b0;
        arm_nxt  = 1'b0;
      end
      if (pwrite) begin
        unique case (paddr)
          `OFF_CONTROL: ctl_nxt = pwdata[7:0];
          `OFF_STATUS:  dbl_nxt = pwdata[`BIT_DOUBLE];
          `OFF_PINS:    pin_nxt = pwdata[4:0];
          `OFF_DATA: begin
            // A write while shifting is dropped: single transmit buffer
            if (!busy) begin
              sh_nxt  = pwdata[7:0];
              out_nxt = lsbf ? pwdata[0] : pwdata[7];
              if (en && mst) begin
                st_nxt   = DEV_RUN;
                dcnt_nxt = 7'h00;
                ecnt_nxt = 4'h0;
              end
            end
          end
        endcase
      end
    end
    if (irq_ack) begin
      flag_nxt = 1'b0;
      arm_nxt  = 1'b0;
    end

    // Master clock generator and shifter
    if (st_r == DEV_RUN) begin
      if (!en || !mst) begin
        st_nxt  = DEV_IDLE;
        sck_nxt = clock_idle_level;
      end else if (dcnt_r == half_m1) begin
        dcnt_nxt = 7'h00;
        sck_nxt  = ~sck_r;
        ecnt_nxt = ecnt_r + 4'h1;
        lead     = ~ecnt_r[0];
        if (lead ^ clock_sample_phase) begin
          sh_nxt = lsbf ? {link.miso, sh_r[7:1]} : {sh_r[6:0], link.miso};
        end else begin
          out_nxt = top;
        end
        if (ecnt_r == `LAST_EDGE) begin
          st_nxt    = DEV_IDLE;
          rxbuf_nxt = sh_nxt;
          done      = 1'b1;
        end
      end else begin
        dcnt_nxt = dcnt_r + 7'h01;
      end
    end else begin
      sck_nxt = clock_idle_level;
    end

    // Slave shifter runs on the synchronised external clock only
    if (en && !mst) begin
      if (ss_s2) begin
        bcnt_nxt = 4'h0;
        out_nxt  = top;
      end else if (sck_s2 != sck_s3) begin
        lead = (sck_s3 == clock_idle_level);
        if (lead ^ clock_sample_phase) begin
          sh_nxt = lsbf ? {mosi_s2, sh_r[7:1]} : {sh_r[6:0], mosi_s2};
          bcnt_nxt = bcnt_r + 4'h1;
          if (bcnt_r == `LAST_BIT) begin
            bcnt_nxt  = 4'h0;
            rxbuf_nxt = sh_nxt;
            done      = 1'b1;
          end
        end else begin
          out_nxt = top;
        end
      end
    end else begin
      bcnt_nxt = 4'h0;
    end

    // Select input pulled low steals master role
    if (en && mst && !pin_r[`PIN_SS_DIR] && !ss_s2) begin
      ctl_nxt[`BIT_MASTER] = 1'b0;
      st_nxt  = DEV_IDLE;
      sck_nxt = clock_idle_level;
      done    = 1'b1;
    end
    if (done) begin
      flag_nxt = 1'b1;
    end
    irq_nxt = ctl_r[`BIT_IRQ_EN] & flag_r & global_irq_enable;

    // Pin order: sck, mosi, miso, ss values then enables
    if (en && mst) begin
      po_nxt = {sck_r, out_r, 1'b0, pin_r[`PIN_SS_LEVEL],
                pin_r[`PIN_SCK_DIR], pin_r[`PIN_MOSI_DIR], 1'b0, pin_r[`PIN_SS_DIR]};
    end else if (en) begin
      po_nxt = {1'b0, 1'b0, out_r, 1'b0,
                1'b0, 1'b0, pin_r[`PIN_MISO_DIR] & ~ss_s2, 1'b0};
    end else begin
      po_nxt = {1'b0, 1'b0, 1'b0, pin_r[`PIN_SS_LEVEL],
                pin_r[`PIN_SCK_DIR], pin_r[`PIN_MOSI_DIR], pin_r[`PIN_MISO_DIR], pin_r[`PIN_SS_DIR]};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= DEV_IDLE; ctl_r <= `CONTROL_RESET; dbl_r <= 1'b0; pin_r <= `PINS_RESET;
      flag_r <= 1'b0; arm_r <= 1'b0; sh_r <= 8'h00; rxbuf_r <= 8'h00;
      out_r <= 1'b0; ecnt_r <= 4'h0; bcnt_r <= 4'h0; dcnt_r <= 7'h00;
      sck_r <= 1'b0; prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
      irq <= 1'b0; po_r <= 8'h00;
      // Sync flops start at the pull-up level so no false edge follows reset
      ss_s1 <= 1'b1; ss_s2 <= 1'b1; sck_s1 <= 1'b1; sck_s2 <= 1'b1; sck_s3 <= 1'b1;
      mosi_s1 <= 1'b1; mosi_s2 <= 1'b1;
    end else begin
      st_r <= st_nxt; ctl_r <= ctl_nxt; dbl_r <= dbl_nxt; pin_r <= pin_nxt;
      flag_r <= flag_nxt; arm_r <= arm_nxt; sh_r <= sh_nxt; rxbuf_r <= rxbuf_nxt;
      out_r <= out_nxt; ecnt_r <= ecnt_nxt; bcnt_r <= bcnt_nxt; dcnt_r <= dcnt_nxt;
      sck_r <= sck_nxt; prdata <= prdata_nxt; pready <= pready_nxt; pslverr <= pslverr_nxt;
      irq <= irq_nxt; po_r <= po_nxt;
      ss_s1 <= link.ss_n; ss_s2 <= ss_s1;
      sck_s1 <= link.sck; sck_s2 <= sck_s1; sck_s3 <= sck_s2;
      mosi_s1 <= link.mosi; mosi_s2 <= mosi_s1;
    end
  end

  assign link.dev_sck_o   = po_r[7];
  assign link.dev_mosi_o  = po_r[6];
  assign link.dev_miso_o  = po_r[5];
  assign link.dev_ss_o    = po_r[4];
  assign link.dev_sck_oe  = po_r[3];
  assign link.dev_mosi_oe = po_r[2];
  assign link.dev_miso_oe = po_r[1];
  assign link.dev_ss_oe   = po_r[0];
endmodule : spi_port

// File: verification/spi_link_sva.sv
// Checker on the link wires between the port and its partner
`timescale 1ns/100ps
module spi_link_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic dev_sck_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic dev_ss_oe,
  input wire logic peer_sck_o,
  input wire logic peer_sck_oe,
  input wire logic peer_ss_o,
  input wire logic peer_ss_oe,
  input wire logic ss_n
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  slave_pins_in_a: assert property (
    dev_miso_oe |-> !dev_mosi_oe && !dev_sck_oe && !dev_ss_oe) else $error("slave drives a master pin");
  master_miso_in_a: assert property (
    dev_sck_oe |-> !dev_miso_oe) else $error("master drives miso");
  desel_miso_off_a: assert property (
    ss_n [*6] |-> !dev_miso_oe) else $error("miso driven while deselected");
  miso_needs_sel_a: assert property (
    $rose(dev_miso_oe) |-> !ss_n && !$past(ss_n, 2)) else $error("miso driven without select");
  // Sync delay sets the eight-cycle margin
  fault_drops_a: assert property (
    (!ss_n && !dev_ss_oe) [*8] |-> !dev_sck_oe && !dev_mosi_oe) else $error("master kept driving");
  master_stays_off_a: assert property (
    $fell(dev_sck_oe) && !dev_ss_oe && !ss_n |=> !dev_sck_oe [*8]) else $error("master came back alone");
  peer_sck_half_a: assert property (
    peer_sck_oe && $changed(peer_sck_o) |=> $stable(peer_sck_o) [*2]) else $error("partner clock phase short");
  peer_lead_a: assert property (
    peer_ss_oe && $fell(peer_ss_o) |=> (!peer_ss_o && $stable(peer_sck_o)) [*2]) else $error("no lead time");

  cover property ($rose(dev_miso_oe));
  cover property ($fell(dev_sck_oe) && !ss_n);
  cover property (peer_sck_oe && $changed(peer_sck_o));
endmodule : spi_link_sva

// File: verification/tb.sv
// Self-checking bench joining the port and its partner over the link
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module tb
  import spi_pkg::*;
;
  localparam int DIV_TAB [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        global_irq_enable, irq_ack, role_master, clock_idle_level, clock_sample_phase, lsb_first, start, busy, done;
  logic        mon_on, sck_q;
  logic [7:0]  paddr, tx_data, rx_data, mbits;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt, n_checks, edges;

  spi_link_if spi_link_if_i ();
  spi_port spi_port_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq(irq), .link(spi_link_if_i));
  // Eight-cycle half period covers the slave's sync and its registered answer
  spi_peer #(.HALF_PERIOD(8)) spi_peer_i (.clock(clock), .resetn(resetn), .role_master(role_master),
    .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase), .lsb_first(lsb_first), .tx_data(tx_data), .start(start), .busy(busy),
    .rx_data(rx_data), .done(done), .link(spi_link_if_i));
  spi_link_sva spi_link_sva_i (.clock(clock), .resetn(resetn), .dev_sck_oe(spi_link_if_i.dev_sck_oe),
    .dev_mosi_oe(spi_link_if_i.dev_mosi_oe), .dev_miso_oe(spi_link_if_i.dev_miso_oe),
    .dev_ss_oe(spi_link_if_i.dev_ss_oe), .peer_sck_o(spi_link_if_i.peer_sck_o),
    .peer_sck_oe(spi_link_if_i.peer_sck_oe), .peer_ss_o(spi_link_if_i.peer_ss_o),
    .peer_ss_oe(spi_link_if_i.peer_ss_oe), .ss_n(spi_link_if_i.ss_n));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Wire monitor: counts clock edges and samples mosi on the sample edges
  always @(posedge clock) begin
    sck_q <= spi_link_if_i.sck;
    if (mon_on && spi_link_if_i.sck !== sck_q) begin
      if (edges[0] == clock_sample_phase) mbits <= {mbits[6:0], spi_link_if_i.mosi};
      edges <= edges + 1;
    end
  end

  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin @(posedge clock); end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task pulse_start;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask : pulse_start

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    apb(1'b0, 8'h00, 32'h0); `CHK(q, 32'h0)
    apb(1'b0, 8'h04, 32'h0); `CHK(q, 32'h0)
    apb(1'b0, 8'h10, 32'h0); `CHK({err, q}, 33'h100000000)
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h0c, 32'h0d);
    // Let the newly driven pins settle before counting clock edges
    repeat (3) @(posedge clock);
    edges = 0; mon_on = 1'b1;
    apb(1'b1, 8'h08, 32'ha5);
    repeat (200) @(posedge clock);
    mon_on = 1'b0;
    `CHK(edges, 0)
    apb(1'b0, 8'h04, 32'h0); `CHK(q[7], 1'b0)
  endtask : t_regs

  task t_master(input int i);
    logic [7:0] b, pb, got;
    int c, d;
    b = 8'h3c ^ 8'(i * 37); pb = ~b ^ 8'h5a; d = DIV_TAB[i];
    apb(1'b1, 8'h00, {24'h0, 2'b11, i[2], 1'b1, i[0], i[1], i[1:0]});
    apb(1'b1, 8'h04, {31'h0, i[2]});
    apb(1'b1, 8'h0c, 32'h1d);
    clock_idle_level <= i[0]; clock_sample_phase <= i[1]; lsb_first <= i[2]; role_master <= 1'b0; tx_data <= pb;
    @(posedge clock);
    pulse_start;
    apb(1'b1, 8'h0c, 32'h0d);
    edges = 0; mbits = 8'h0; mon_on = 1'b1;
    `CHK(spi_link_if_i.sck, i[0])
    apb(1'b1, 8'h08, {24'h0, b});
    apb(1'b1, 8'h08, {24'h0, ~b});
    c = 0;
    while (irq !== 1'b1 && c < 3000) begin @(posedge clock); c++; end
    // Second write costs three cycles before counting starts
    `CHK((c + 3 >= 8 * d) && (c + 3 <= 8 * d + 4), 1'b1)
    repeat (4) @(posedge clock);
    mon_on = 1'b0;
    got = i[2] ? {<<{mbits}} : mbits;
    `CHK(edges, 16)
    `CHK(got, b)
    `CHK(rx_data, b)
    apb(1'b0, 8'h04, 32'h0); `CHK(q[7], 1'b1)
    // Below a divide of eight the partner answers after the sample edge, so its byte is judged from there up
    apb(1'b0, 8'h08, 32'h0); if (d >= 8) `CHK(q, {24'h0, pb})
    apb(1'b0, 8'h04, 32'h0); `CHK(q[7], 1'b0)
    `CHK(irq, 1'b0)
    apb(1'b0, 8'h00, 32'h0); `CHK(q[4], 1'b1)
    apb(1'b1, 8'h0c, 32'h1d);
  endtask : t_master

  task t_slave(input int m);
    logic [7:0] b, pb;
    int c;
    b = 8'h96 ^ 8'(m * 19); pb = 8'h0f ^ 8'(m * 77);
    apb(1'b1, 8'h00, {24'h0, 2'b01, m[2], 1'b0, m[0], m[1], 2'b11});
    apb(1'b1, 8'h0c, 32'h02);
    apb(1'b1, 8'h08, {24'h0, b});
    clock_idle_level <= m[0]; clock_sample_phase <= m[1]; lsb_first <= m[2]; tx_data <= pb;
    // Partner clock reaches its new idle level before it is driven
    repeat (2) @(posedge clock);
    role_master <= 1'b1;
    repeat (4) @(posedge clock);
    pulse_start;
    c = 0;
    while (done !== 1'b1 && c < 500) begin @(posedge clock); c++; end
    `CHK(done, 1'b1)
    `CHK(rx_data, b)
    role_master <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1'b0, 8'h04, 32'h0); `CHK(q[7], 1'b1)
    apb(1'b0, 8'h08, 32'h0); `CHK(q, {24'h0, pb})
  endtask : t_slave

  task t_fault;
    int c;
    global_irq_enable <= 1'b0;
    apb(1'b1, 8'h00, 32'hd0);
    apb(1'b1, 8'h0c, 32'h05);
    clock_idle_level <= 1'b0; clock_sample_phase <= 1'b0; lsb_first <= 1'b0; tx_data <= 8'h81;
    repeat (2) @(posedge clock);
    role_master <= 1'b1;
    repeat (4) @(posedge clock);
    pulse_start;
    c = 0;
    while (done !== 1'b1 && c < 500) begin @(posedge clock); c++; end
    `CHK(done, 1'b1)
    repeat (8) @(posedge clock);
    `CHK(irq, 1'b0)
    apb(1'b0, 8'h00, 32'h0); `CHK(q[7:0], 8'hc0)
    apb(1'b0, 8'h04, 32'h0); `CHK(q[7], 1'b1)
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b1)
    irq_ack <= 1'b1;
    @(posedge clock);
    irq_ack <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0)
    apb(1'b0, 8'h04, 32'h0); `CHK(q[7], 1'b0)
    role_master <= 1'b0;
    apb(1'b1, 8'h00, 32'hd0);
    apb(1'b0, 8'h00, 32'h0); `CHK(q[4], 1'b1)
  endtask : t_fault

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    global_irq_enable = 1'b0; irq_ack = 1'b0; role_master = 1'b0; clock_idle_level = 1'b0; clock_sample_phase = 1'b0;
    lsb_first = 1'b0; tx_data = 8'h0; start = 1'b0; mon_on = 1'b0; sck_q = 1'b1; mbits = 8'h0;
    edges = 0; error_cnt = 0; n_checks = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_regs;
    global_irq_enable <= 1'b1;
    for (int i = 0; i < 8; i++) t_master(i);
    for (int i = 0; i < 8; i++) t_slave(i);
    t_fault;
    end_sim;
  end

  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    end_sim;
  end
endmodule : tb
